// [fiap_pkg.sv]
package fiap_pkg;
    // Register byte offsets on the APB bus.
    localparam logic [7:0] OFF_STATUS = 8'h00;
    localparam logic [7:0] OFF_CMD = 8'h04;
    localparam logic [7:0] OFF_ADDR_LO = 8'h08;
    localparam logic [7:0] OFF_ADDR_HI = 8'h0c;
    localparam logic [7:0] OFF_DATA = 8'h10;
    localparam logic [7:0] OFF_CONFIG = 8'h14;
    // Field positions.
    localparam int BUSY_BIT = 2;
    localparam int IAP_EN_BIT = 6;
    localparam int BANK_BIT = 0;
    localparam int CFG_MIRROR_BIT = 1;
    localparam int IRQ_SEL_BIT = 7;
    // Reset values.
    localparam logic [7:0] RST_BYTE = 8'h00;
    // Command codes and keys.
    localparam logic [6:0] CMD_CHIP = 7'h01;
    localparam logic [6:0] CMD_BLOCK = 7'h0d;
    localparam logic [6:0] CMD_SECTOR = 7'h0b;
    localparam logic [6:0] CMD_PROG = 7'h0e;
    localparam logic [6:0] CMD_VERIFY = 7'h0c;
    localparam logic [6:0] CMD_SB_A = 7'h0f;
    localparam logic [6:0] CMD_SB_B = 7'h03;
    localparam logic [6:0] CMD_SB_C = 7'h05;
    localparam logic [6:0] CMD_SC = 7'h09;
    localparam logic [6:0] CMD_CLKDBL = 7'h08;
    localparam logic [7:0] KEY_ERASE = 8'h55;
    localparam logic [7:0] KEY_CFG = 8'haa;
    localparam logic [7:0] AH_SC_A = 8'h5a;
    localparam logic [7:0] AH_SC_B = 8'haa;
    localparam logic [7:0] AH_CLKDBL = 8'h55;
    localparam logic [3:0] AH_BLK1_NIB = 4'he;
    localparam logic [2:0] LOCK_LEVEL_MAX = 3'h4;
    localparam logic [15:0] SECTOR_MASK = 16'hff80;
    localparam logic [7:0] OVERLAY_TOP = 8'h20;
    // Signature addresses; codes are arbitrary neutral values.
    localparam logic [7:0] SIG_MFR_ADDR = 8'h30;
    localparam logic [7:0] SIG_DEV_ADDR = 8'h31;
    localparam logic [7:0] SIG_MFR_CODE = 8'h5c;
    localparam logic [7:0] SIG_DEV_CODE = 8'h3a;
    localparam logic [7:0] SIG_NONE = 8'hff;

    typedef enum logic [1:0] {SRC_BLK0, SRC_BLK1, SRC_EXT} fiap_src_t;
    typedef enum logic [3:0] {
        OP_CHIP, OP_BLOCK, OP_SECTOR, OP_PROG, OP_VERIFY,
        OP_SB_A, OP_SB_B, OP_SB_C, OP_SC_A, OP_SC_B, OP_CLKDBL
    } fiap_op_t;
    typedef struct packed {
        fiap_op_t op;
        logic block;
        logic [15:0] addr;
        logic [7:0] wdata;
    } fiap_arr_t;
endpackage

// [fiap_sequencer.sv]
// Notes on behaviour
// - Commands ignored until programming enable set.
// - Only a command-register write starts operations.
// - Commands to a locked block are refused.
// - Block 0 code targets block 1, vice versa.
// - Chip erase needs external pin low, not level 4.
// - Chip erase ignores locks, clears security, remap.
// - Block erase selects block by address high.
// - Sector erase uses combined address, 128 bytes.
// - Byte program writes data register to address.
// - Byte verify loads data register, no interrupt.
// - Security bits only move to programmed, except by chip erase.
// - Boot select changes only after reset.
// - Config bit 1 mirror changes after reset.
// - Clock-double command selects six clocks per cycle.
// - Busy flag high during operation, low when ready.
// - Code read to a busy block fails; here a read during a byte verify does not fail.
// - Bit 7 gives external interrupt one on completion.
// - Timing oscillator runs only during operations.
// - Signature returns maker and device codes.
//
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/100ps
`default_nettype none
module fiap_sequencer (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Core context and device state.
    input wire fiap_pkg::fiap_src_t fetchSrc,
    input wire logic extAccessPinN,
    input wire logic [2:0] lockLevel,
    input wire logic [1:0] blockLocked,
    input wire logic [2:0] nvSecBits,
    input wire logic nvStartCfgA,
    input wire logic nvStartCfgB,
    // Flash array.
    output logic arrReq,
    output fiap_pkg::fiap_arr_t arrCmd,
    input wire logic arrDone,
    input wire logic [7:0] arrRdata,
    // Timing oscillator.
    output logic oscEnable,
    // Code-space read check.
    input wire logic codeRdReq,
    input wire logic codeRdBlock,
    output logic codeRdFail,
    // Interrupt one.
    output logic extIrqOne,
    output logic irqPinIsGpio,
    // Configuration outputs.
    output logic [2:0] secBits,
    output logic bootBlockSelect,
    output logic clockDouble,
    // Signature read.
    input wire logic [7:0] sigAddr,
    output logic [7:0] sigData
);
    import fiap_pkg::*;

    typedef enum {ST_IDLE, ST_RUN} fiap_state_t;

    fiap_state_t state_q;
    logic busy;
    logic done;
    logic wrAcc;
    logic cmdWr;
    logic accept;
    logic cmdOk;
    logic blkValid;
    logic blk;
    logic overlay;
    fiap_op_t opNew;
    logic [7:0] cmdReg_q;
    logic [7:0] addrLo_q;
    logic [7:0] addrHi_q;
    logic [7:0] data_q;
    logic iapEn_q;
    logic bank_q;
    logic cfgMirror_q;
    logic capDone_q;
    logic irqSel_q;
    logic [2:0] secBits_q;
    logic startCfgA_q;
    logic startCfgB_q;
    logic clockDouble_q;
    logic extIrqOne_q;
    logic [7:0] sigData_q;
    fiap_arr_t arr_q;

    // Returns {valid, block} for an address high byte from external code.
    function automatic logic [1:0] ext_block(input logic [7:0] ah, input logic ovl);
        if (!ah[7]) begin
            return {1'b1, ovl && (ah < OVERLAY_TOP)};
        end else if (ah[7:4] == AH_BLK1_NIB) begin
            return 2'b11;
        end else begin
            return 2'b00;
        end
    endfunction

    assign busy = (state_q == ST_RUN);
    assign done = busy && arrDone;
    assign wrAcc = psel && penable && pwrite;
    assign cmdWr = wrAcc && (paddr == OFF_CMD);
    assign overlay = bank_q || cfgMirror_q;
    assign pready = 1'b1;

    always_comb begin
        logic [1:0] eb;
        eb = ext_block(addrHi_q, overlay);
        case (fetchSrc)
            SRC_BLK0: begin
                blkValid = 1'b1;
                blk = 1'b1;
            end
            SRC_BLK1: begin
                blkValid = 1'b1;
                blk = 1'b0;
            end
            default: begin
                blkValid = eb[1];
                blk = eb[0];
            end
        endcase
    end

    always_comb begin
        logic [7:0] dt;
        logic blkOk;
        dt = data_q;
        blkOk = blkValid && !blockLocked[blk];
        cmdOk = 1'b0;
        opNew = OP_VERIFY;
        case (pwdata[6:0])
            CMD_CHIP: begin
                opNew = OP_CHIP;
                cmdOk = (dt == KEY_ERASE) && !extAccessPinN && (lockLevel != LOCK_LEVEL_MAX);
            end
            CMD_BLOCK: begin
                opNew = OP_BLOCK;
                cmdOk = (dt == KEY_ERASE) && blkOk;
            end
            CMD_SECTOR: begin
                opNew = OP_SECTOR;
                cmdOk = blkOk;
            end
            CMD_PROG: begin
                opNew = OP_PROG;
                cmdOk = blkOk;
            end
            CMD_VERIFY: begin
                opNew = OP_VERIFY;
                cmdOk = blkOk;
            end
            CMD_SB_A: begin
                opNew = OP_SB_A;
                cmdOk = (dt == KEY_CFG);
            end
            CMD_SB_B: begin
                opNew = OP_SB_B;
                cmdOk = (dt == KEY_CFG);
            end
            CMD_SB_C: begin
                opNew = OP_SB_C;
                cmdOk = (dt == KEY_CFG);
            end
            CMD_SC: begin
                opNew = (addrHi_q == AH_SC_A) ? OP_SC_A : OP_SC_B;
                cmdOk = (dt == KEY_CFG) && ((addrHi_q == AH_SC_A) || (addrHi_q == AH_SC_B));
            end
            CMD_CLKDBL: begin
                opNew = OP_CLKDBL;
                cmdOk = (dt == KEY_CFG) && (addrHi_q == AH_CLKDBL);
            end
            default: begin
                opNew = OP_VERIFY;
                cmdOk = 1'b0;
            end
        endcase
    end

    // Commands arriving while busy are dropped rather than queued.
    assign accept = cmdWr && iapEn_q && !busy && cmdOk;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= ST_IDLE;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (accept) begin
                        state_q <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (arrDone) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            arr_q <= '0;
            irqSel_q <= 1'b0;
        end else if (accept) begin
            arr_q.op <= opNew;
            arr_q.block <= blk;
            arr_q.addr <= (opNew == OP_SECTOR) ? ({addrHi_q, addrLo_q} & SECTOR_MASK) : {addrHi_q, addrLo_q};
            arr_q.wdata <= data_q;
            irqSel_q <= pwdata[IRQ_SEL_BIT];
        end
    end

    assign arrReq = busy;
    assign arrCmd = arr_q;
    assign oscEnable = busy && (arr_q.op != OP_VERIFY);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cmdReg_q <= RST_BYTE;
            addrLo_q <= RST_BYTE;
            addrHi_q <= RST_BYTE;
            iapEn_q <= 1'b0;
            bank_q <= 1'b0;
        end else if (wrAcc) begin
            case (paddr)
                OFF_CMD: cmdReg_q <= pwdata[7:0];
                OFF_ADDR_LO: addrLo_q <= pwdata[7:0];
                OFF_ADDR_HI: addrHi_q <= pwdata[7:0];
                OFF_CONFIG: begin
                    iapEn_q <= pwdata[IAP_EN_BIT];
                    bank_q <= pwdata[BANK_BIT];
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            data_q <= RST_BYTE;
        end else if (done && (arr_q.op == OP_VERIFY)) begin
            data_q <= arrRdata;
        end else if (wrAcc && (paddr == OFF_DATA)) begin
            data_q <= pwdata[7:0];
        end
    end

    // Nonvolatile state is captured once, on the first edge after reset release.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            capDone_q <= 1'b0;
            bootBlockSelect <= 1'b0;
            cfgMirror_q <= 1'b0;
        end else if (!capDone_q) begin
            capDone_q <= 1'b1;
            bootBlockSelect <= nvStartCfgA;
            cfgMirror_q <= nvStartCfgB;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            secBits_q <= 3'h0;
            startCfgA_q <= 1'b0;
            startCfgB_q <= 1'b0;
            clockDouble_q <= 1'b0;
        end else if (!capDone_q) begin
            secBits_q <= nvSecBits;
            startCfgA_q <= nvStartCfgA;
            startCfgB_q <= nvStartCfgB;
        end else if (done) begin
            case (arr_q.op)
                OP_CHIP: begin
                    secBits_q <= 3'h0;
                    startCfgA_q <= 1'b0;
                    startCfgB_q <= 1'b0;
                end
                OP_SB_A: secBits_q[0] <= 1'b1;
                OP_SB_B: secBits_q[1] <= 1'b1;
                OP_SB_C: secBits_q[2] <= 1'b1;
                OP_SC_A: startCfgA_q <= 1'b1;
                OP_SC_B: startCfgB_q <= 1'b1;
                OP_CLKDBL: clockDouble_q <= 1'b1;
                default: begin
                end
            endcase
        end
    end

    assign secBits = secBits_q;
    assign clockDouble = clockDouble_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            extIrqOne_q <= 1'b0;
        end else begin
            extIrqOne_q <= done && irqSel_q && (arr_q.op != OP_VERIFY);
        end
    end

    assign extIrqOne = extIrqOne_q;
    assign irqPinIsGpio = busy && irqSel_q;

    // A chip erase occupies both blocks.
    assign codeRdFail = codeRdReq && busy && (arr_q.op inside {OP_CHIP, OP_BLOCK, OP_SECTOR, OP_PROG})
                        && ((arr_q.op == OP_CHIP) || (arr_q.block == codeRdBlock));

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sigData_q <= SIG_NONE;
        end else begin
            case (sigAddr)
                SIG_MFR_ADDR: sigData_q <= SIG_MFR_CODE;
                SIG_DEV_ADDR: sigData_q <= SIG_DEV_CODE;
                default: sigData_q <= SIG_NONE;
            endcase
        end
    end

    assign sigData = sigData_q;

    always_comb begin
        prdata = 32'h0;
        pslverr = 1'b0;
        case (paddr)
            OFF_STATUS: prdata[BUSY_BIT] = busy;
            OFF_CMD: prdata[7:0] = cmdReg_q;
            OFF_ADDR_LO: prdata[7:0] = addrLo_q;
            OFF_ADDR_HI: prdata[7:0] = addrHi_q;
            OFF_DATA: prdata[7:0] = data_q;
            OFF_CONFIG: begin
                prdata[IAP_EN_BIT] = iapEn_q;
                prdata[CFG_MIRROR_BIT] = cfgMirror_q;
                prdata[BANK_BIT] = bank_q;
            end
            default: pslverr = psel && penable;
        endcase
    end

    a_iap_gate: assert property (@(posedge clk) disable iff (rst)
        (cmdWr && !iapEn_q) |-> !accept) else $error("command accepted with programming disabled");
    a_start_busy: assert property (@(posedge clk) disable iff (rst)
        accept |=> busy && arrReq) else $error("accepted command did not raise busy");
    a_ignore_quiet: assert property (@(posedge clk) disable iff (rst)
        (cmdWr && !accept && !busy) |=> !busy ##1 !extIrqOne) else $error("ignored command had effect");
    a_chip_precond: assert property (@(posedge clk) disable iff (rst)
        (accept && opNew == OP_CHIP) |-> (!extAccessPinN && lockLevel != LOCK_LEVEL_MAX))
        else $error("chip erase accepted without its preconditions");
    a_lock_refuse: assert property (@(posedge clk) disable iff (rst)
        (accept && opNew inside {OP_BLOCK, OP_SECTOR, OP_PROG, OP_VERIFY}) |-> !blockLocked[blk])
        else $error("command accepted on locked block");
    a_cross_block: assert property (@(posedge clk) disable iff (rst)
        (accept && fetchSrc == SRC_BLK0 && opNew != OP_CHIP) |=> arrCmd.block)
        else $error("block 0 code did not target block 1");
    a_irq_done: assert property (@(posedge clk) disable iff (rst)
        (done && irqSel_q && arr_q.op != OP_VERIFY) |=> extIrqOne ##1 !extIrqOne)
        else $error("completion interrupt missing or too long");
    a_verify_noirq: assert property (@(posedge clk) disable iff (rst)
        (done && arr_q.op == OP_VERIFY) |=> !extIrqOne && data_q == $past(arrRdata))
        else $error("verify raised interrupt or lost data");
    a_boot_steady: assert property (@(posedge clk) disable iff (rst)
        $past(capDone_q) |-> $stable(bootBlockSelect) && $stable(cfgMirror_q))
        else $error("start configuration changed without reset");
    a_sec_monotone: assert property (@(posedge clk) disable iff (rst)
        $past(capDone_q) && !($past(done) && $past(arr_q.op) == OP_CHIP) |-> ($past(secBits_q) & ~secBits_q) == 3'h0)
        else $error("security bit returned to unprogrammed");
    a_osc_off: assert property (@(posedge clk) disable iff (rst)
        done |=> !oscEnable) else $error("oscillator left running");

    c_prog_irq: cover property (@(posedge clk) disable iff (rst)
        accept && opNew == OP_PROG && pwdata[IRQ_SEL_BIT] ##[1:50] extIrqOne);
    c_chip_erase: cover property (@(posedge clk) disable iff (rst) done && arr_q.op == OP_CHIP);
    c_verify: cover property (@(posedge clk) disable iff (rst) done && arr_q.op == OP_VERIFY);
    c_busy_refused: cover property (@(posedge clk) disable iff (rst) cmdWr && busy);
endmodule
`default_nettype wire

// [fiap_sequencer_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module fiap_sequencer_tb;
    import fiap_pkg::*;
    logic clk, rst, psel, penable, pwrite, pready, pslverr, extAccessPinN, nvStartCfgA, nvStartCfgB;
    logic [7:0] paddr, arrRdata, sigAddr, sigData;
    logic [31:0] pwdata, prdata;
    fiap_src_t fetchSrc;
    logic [2:0] lockLevel, nvSecBits, secBits;
    logic [1:0] blockLocked;
    fiap_arr_t arrCmd;
    logic arrReq, arrDone, oscEnable, codeRdReq, codeRdBlock, codeRdFail;
    logic extIrqOne, irqPinIsGpio, bootBlockSelect, clockDouble;
    int n_fail = 0;
    int checked = 0;

    fiap_sequencer i_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .fetchSrc(fetchSrc), .extAccessPinN(extAccessPinN), .lockLevel(lockLevel),
        .blockLocked(blockLocked), .nvSecBits(nvSecBits), .nvStartCfgA(nvStartCfgA),
        .nvStartCfgB(nvStartCfgB), .arrReq(arrReq), .arrCmd(arrCmd), .arrDone(arrDone),
        .arrRdata(arrRdata), .oscEnable(oscEnable), .codeRdReq(codeRdReq), .codeRdBlock(codeRdBlock),
        .codeRdFail(codeRdFail), .extIrqOne(extIrqOne), .irqPinIsGpio(irqPinIsGpio), .secBits(secBits),
        .bootBlockSelect(bootBlockSelect), .clockDouble(clockDouble), .sigAddr(sigAddr), .sigData(sigData));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic tally_and_finish;
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t %s seen %h exp %h", $time, m, seen, exp);
        end
    endtask

    // Entered just after a rising edge; returns one idle cycle after the release.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        // Only the watchdog ends a wait for the slave's answer.
        while (pready !== 1'b1) begin
            @(posedge clk);
            n++;
        end
        r = prdata;
        e = pslverr;
        chk(n, 32'h0, "wait states");
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        logic e;
        apb(1'b0, a, 32'h0, r, e);
    endtask

    // Loads the mailbox, issues one command and, if accepted, completes it from the array side.
    task automatic run_op(input fiap_src_t src, input logic [7:0] ah, al, dt, cm, input logic ok,
                          input fiap_op_t op, input logic [1:0] blk, input logic [15:0] ad);
        logic [31:0] r;
        logic irqExp;
        irqExp = cm[7] && (op != OP_VERIFY);
        fetchSrc <= src;
        wr(OFF_ADDR_HI, {24'h0, ah});
        wr(OFF_ADDR_LO, {24'h0, al});
        wr(OFF_DATA, {24'h0, dt});
        chk({31'h0, arrReq}, 32'h0, "early start");
        wr(OFF_CMD, {24'h0, cm});
        @(negedge clk);
        chk({31'h0, arrReq}, {31'h0, ok}, "accept");
        if (ok) begin
            chk({28'h0, arrCmd.op}, {28'h0, op}, "op");
            if (!blk[1]) chk({31'h0, arrCmd.block}, {31'h0, blk[0]}, "block");
            if (op inside {OP_PROG, OP_VERIFY, OP_SECTOR}) chk({16'h0, arrCmd.addr}, {16'h0, ad}, "addr");
            if (op == OP_PROG) chk({24'h0, arrCmd.wdata}, {24'h0, dt}, "wdata");
            chk({31'h0, oscEnable}, {31'h0, op != OP_VERIFY}, "osc on");
            if (op != OP_VERIFY) chk({31'h0, irqPinIsGpio}, {31'h0, irqExp}, "pin mode");
            @(posedge clk);
            rd(OFF_STATUS, r);
            chk(r, 32'h4, "busy read");
            if (op inside {OP_PROG, OP_BLOCK, OP_SECTOR}) begin
                codeRdBlock <= blk[0];
                @(negedge clk);
                chk({31'h0, codeRdFail}, 32'h1, "busy fetch");
                @(posedge clk);
                codeRdBlock <= ~blk[0];
                @(negedge clk);
                chk({31'h0, codeRdFail}, 32'h0, "idle fetch");
                @(posedge clk);
            end
            arrDone <= 1'b1;
            @(posedge clk);
            arrDone <= 1'b0;
            @(negedge clk);
            chk({31'h0, extIrqOne}, {31'h0, irqExp}, "irq");
            chk({30'h0, arrReq, oscEnable}, 32'h0, "done");
            @(negedge clk);
            chk({31'h0, extIrqOne}, 32'h0, "irq width");
        end else begin
            repeat (2) @(negedge clk);
            chk({30'h0, extIrqOne, arrReq}, 32'h0, "ignored");
        end
        @(posedge clk);
    endtask

    task automatic t_reset_and_bus;
        logic [31:0] r;
        logic e;
        @(negedge clk);
        chk({27'h0, secBits, bootBlockSelect, clockDouble}, 32'h4, "nv capture");
        @(posedge clk);
        rd(OFF_STATUS, r);
        chk(r, 32'h0, "status rst");
        rd(OFF_CONFIG, r);
        chk(r, 32'h0, "config rst");
        apb(1'b1, 8'h18, 32'hff, r, e);
        chk({31'h0, e}, 32'h1, "unmapped wr");
        apb(1'b0, 8'h18, 32'h0, r, e);
        chk({r[30:0], e}, 32'h1, "unmapped rd");
        wr(OFF_STATUS, 32'h4);
        rd(OFF_STATUS, r);
        chk(r, 32'h0, "status ro");
    endtask

    task automatic t_erase_and_program;
        run_op(SRC_BLK1, 8'h12, 8'h34, 8'ha5, 8'h8e, 1'b0, OP_PROG, 2'b00, 16'h0);
        wr(OFF_CONFIG, 32'h40);
        run_op(SRC_BLK0, 8'h12, 8'h34, 8'ha5, 8'h8e, 1'b1, OP_PROG, 2'b01, 16'h1234);
        run_op(SRC_BLK1, 8'h7f, 8'hff, 8'h3c, 8'h0e, 1'b1, OP_PROG, 2'b00, 16'h7fff);
        run_op(SRC_EXT, 8'h12, 8'h00, 8'h55, 8'h8d, 1'b1, OP_BLOCK, 2'b00, 16'h0);
        run_op(SRC_EXT, 8'he3, 8'h00, 8'h55, 8'h0d, 1'b1, OP_BLOCK, 2'b01, 16'h0);
        run_op(SRC_EXT, 8'h93, 8'h00, 8'h55, 8'h0d, 1'b0, OP_BLOCK, 2'b00, 16'h0);
        run_op(SRC_EXT, 8'h12, 8'h00, 8'h00, 8'h0d, 1'b0, OP_BLOCK, 2'b00, 16'h0);
        run_op(SRC_EXT, 8'h12, 8'hb7, 8'h00, 8'h0b, 1'b1, OP_SECTOR, 2'b00, 16'h1280);
        blockLocked <= 2'b10;
        run_op(SRC_BLK0, 8'h12, 8'h34, 8'ha5, 8'h0e, 1'b0, OP_PROG, 2'b01, 16'h0);
        run_op(SRC_EXT, 8'he3, 8'h00, 8'h55, 8'h0d, 1'b0, OP_BLOCK, 2'b01, 16'h0);
        run_op(SRC_EXT, 8'h00, 8'h00, 8'h55, 8'h01, 1'b0, OP_CHIP, 2'b10, 16'h0);
        extAccessPinN <= 1'b0;
        lockLevel <= 3'h4;
        run_op(SRC_EXT, 8'h00, 8'h00, 8'h55, 8'h01, 1'b0, OP_CHIP, 2'b10, 16'h0);
        lockLevel <= 3'h3;
        blockLocked <= 2'b11;
        run_op(SRC_EXT, 8'h00, 8'h00, 8'h55, 8'h81, 1'b1, OP_CHIP, 2'b10, 16'h0);
        chk({29'h0, secBits}, 32'h0, "chip clears sec");
        blockLocked <= 2'b00;
        lockLevel <= 3'h0;
        arrRdata <= 8'hc3;
        run_op(SRC_EXT, 8'h12, 8'h34, 8'h00, 8'h8c, 1'b1, OP_VERIFY, 2'b00, 16'h1234);
    endtask

    task automatic t_security_and_config;
        logic [31:0] r;
        logic [7:0] cmds[4] = '{8'h0f, 8'h83, 8'h05, 8'h0f};
        fiap_op_t ops[4] = '{OP_SB_A, OP_SB_B, OP_SB_C, OP_SB_A};
        rd(OFF_DATA, r);
        chk(r, 32'hc3, "verify data");
        run_op(SRC_EXT, 8'h00, 8'h00, 8'h00, 8'h0f, 1'b0, OP_SB_A, 2'b10, 16'h0);
        for (int i = 0; i < 4; i++) begin
            run_op(SRC_EXT, 8'h00, 8'h00, 8'haa, cmds[i], 1'b1, ops[i], 2'b10, 16'h0);
            chk(32'($countones(secBits)), (i < 3) ? i + 1 : 3, "sec bits");
        end
        run_op(SRC_EXT, 8'h5a, 8'h00, 8'haa, 8'h09, 1'b1, OP_SC_A, 2'b10, 16'h0);
        chk({31'h0, bootBlockSelect}, 32'h0, "boot held");
        run_op(SRC_EXT, 8'haa, 8'h00, 8'haa, 8'h09, 1'b1, OP_SC_B, 2'b10, 16'h0);
        rd(OFF_CONFIG, r);
        chk(r, 32'h40, "mirror held");
        run_op(SRC_EXT, 8'h33, 8'h00, 8'haa, 8'h09, 1'b0, OP_SC_A, 2'b10, 16'h0);
        run_op(SRC_EXT, 8'h55, 8'h00, 8'haa, 8'h08, 1'b1, OP_CLKDBL, 2'b10, 16'h0);
        chk({31'h0, clockDouble}, 32'h1, "clock double");
    endtask

    task automatic t_signature_and_reset;
        logic [31:0] r;
        logic [7:0] adr[3] = '{SIG_MFR_ADDR, SIG_DEV_ADDR, 8'h32};
        logic [7:0] exp[3] = '{SIG_MFR_CODE, SIG_DEV_CODE, SIG_NONE};
        for (int i = 0; i < 3; i++) begin
            sigAddr <= adr[i];
            @(posedge clk);
            @(negedge clk);
            chk({24'h0, sigData}, {24'h0, exp[i]}, "signature");
            @(posedge clk);
        end
        nvStartCfgA <= 1'b1;
        nvStartCfgB <= 1'b1;
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk({30'h0, bootBlockSelect, clockDouble}, 32'h2, "boot after rst");
        @(posedge clk);
        rd(OFF_CONFIG, r);
        chk(r, 32'h2, "mirror after rst");
    endtask

    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        fetchSrc = SRC_EXT;
        extAccessPinN = 1'b1;
        lockLevel = 3'h0;
        blockLocked = 2'b00;
        nvSecBits = 3'h1;
        nvStartCfgA = 1'b0;
        nvStartCfgB = 1'b0;
        arrDone = 1'b0;
        arrRdata = 8'h00;
        codeRdReq = 1'b1;
        codeRdBlock = 1'b0;
        sigAddr = 8'h00;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        t_reset_and_bus();
        t_erase_and_program();
        t_security_and_config();
        t_signature_and_reset();
        tally_and_finish();
    end

    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
